// ===== rtl/cos_pkg.sv
// Package with constants for the clock output select block
package cos_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // Register byte addresses
   localparam logic [7:0] TRIG_CTRL_ADDR = 8'h00;
   localparam logic [7:0] CLK_CFG_ADDR   = 8'h04;
   localparam logic [7:0] STATUS_ADDR    = 8'h08;
   // Trigger control fields
   localparam int TRIG_EN_BIT   = 0;
   localparam int TRIG_MODE_LSB = 1;
   localparam int TRIG_DIV_LSB  = 8;
   localparam int TRIG_DIV_W    = 8;
   localparam logic [1:0] TRIG_MODE_SPLL = 2'h1;
   localparam logic [1:0] TRIG_MODE_TS   = 2'h3;
   localparam logic [7:0] TRIG_DIV_RST   = 8'h01;
   // Clock config fields
   localparam int REF_EN_BIT  = 0;
   localparam int OVR_BIT     = 1;
   localparam int MODE_A_LSB  = 2;
   localparam int MODE_B_LSB  = 4;
   localparam int FLAG_EN_BIT = 6;
   localparam logic REF_EN_RST = 1'b1;
   // Output sources
   localparam int SRC_W = 3;
   localparam logic [2:0] SRC_OFF  = 3'h0;
   localparam logic [2:0] SRC_REF  = 3'h1;
   localparam logic [2:0] SRC_DIV2 = 3'h2;
   localparam logic [2:0] SRC_DIV4 = 3'h3;
   localparam logic [2:0] SRC_FLAG = 3'h4;
   localparam logic [2:0] SRC_SPLL = 3'h5;
   localparam logic [2:0] SRC_TS   = 3'h6;
   // Output indices
   localparam int NOUT  = 4;
   localparam int O_REF = 0;
   localparam int O_TRG = 1;
   localparam int O_A   = 2;
   localparam int O_B   = 3;
   // Synchronised pin indices
   localparam int NPIN   = 9;
   localparam int P_DREF = 0;
   localparam int P_SREF = 1;
   localparam int P_SEL  = 2;
   localparam int P_PLL  = 3;
   localparam int P_PD   = 4;
   localparam int P_ST0  = 5;
   localparam int P_ST1  = 6;
   localparam int P_TS   = 7;
   localparam int P_SPLL = 8;
endpackage

// ===== rtl/cos_clock_output_select.sv
// Clock output selection and gating for the auxiliary clock outputs
`timescale 1ns/1ps
// How it works
// - Reference repeat forwards the reference chosen by the source select pin.
// - Reference repeat is on by default; software clears its enable to stop it.
// - Reference repeat runs only with PLL enable high and power-down low.
// - Trigger output sources the timestamp input or the serializer PLL clock.
// - Trigger output is off after reset; host software must enable it.
// - Serializer source is divided; enable, mode, divider share one register.
// - CMOS outputs run from reset per straps unless power-down is high.
// - Override bit set selects register modes, cleared selects strap pins.
// - Straps enable both CMOS outputs but divide only the first one.
// - A selected clock function wins over the over-range flag.
// - With override set, second CMOS output clocks only when first register mode is nonzero.
// - First output: 0 off or flag, 1 ref, 2 ref/2, 3 ref/4.
// - Second output: any nonzero strap code gives ref; register gives ref, /2, /4.
// - Trigger enabled with mode 3 repeats the retimed timestamp.
// - Timestamp is resynchronised to the internal clock before use.
module cos_clock_output_select (
   input  wire logic                       clk_in,
   input  wire logic                       rst_in,
   input  wire logic [cos_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [cos_pkg::DATA_W-1:0] wdata_in,
   input  wire logic                       wr_in,
   input  wire logic                       rd_in,
   output logic      [cos_pkg::DATA_W-1:0] rdata_out,
   input  wire logic                       diff_ref_in,
   input  wire logic                       single_ended_ref_in,
   input  wire logic                       ref_source_single_ended_sel,
   input  wire logic                       pll_enable_in,
   input  wire logic                       power_down_pin,
   input  wire logic [1:0]                 clock_strap_pins,
   input  wire logic                       timestamp_in,
   input  wire logic                       serdes_pll_in,
   input  wire logic                       quad_part_in,
   input  wire logic                       overrange_c_in,
   input  wire logic                       overrange_d_in,
   output logic                            ref_repeat_out,
   output logic                            trigger_clock_out,
   output logic                            cmos_clk_out_a,
   output logic                            cmos_clk_out_b
);
   import cos_pkg::*;

   logic [NPIN-1:0]       pin_raw;
   logic [NPIN-1:0]       pin_meta;
   logic [NPIN-1:0]       pin_s;
   logic                  trigger_out_enable;
   logic [1:0]            trigger_out_source_mode;
   logic [TRIG_DIV_W-1:0] trig_div;
   logic                  ref_repeat_enable;
   logic                  strap_override_enable;
   logic [1:0]            cmos_a_ref_mode;
   logic [1:0]            cmos_b_ref_mode;
   logic                  overrange_flag_enable;
   logic                  ref_src;
   logic                  ref_prev;
   logic                  ref_div2;
   logic                  ref_div4;
   logic                  spll_prev;
   logic                  spll_div;
   logic [TRIG_DIV_W-1:0] spll_cnt;
   logic [1:0]            mode_a;
   logic [NOUT-1:0]       out_q;
   logic [SRC_W-1:0]      want   [NOUT];
   logic [SRC_W-1:0]      cur    [NOUT];
   logic [7:0]            src    [NOUT];

   assign pin_raw = {serdes_pll_in, timestamp_in, clock_strap_pins,
                     power_down_pin, pll_enable_in,
                     ref_source_single_ended_sel, single_ended_ref_in,
                     diff_ref_in};

   // Two-flop synchronisers for every pin input except quad part and over-range inputs
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pin_meta <= '0;
         pin_s    <= '0;
      end else begin
         pin_meta <= pin_raw;
         pin_s    <= pin_meta;
      end
   end

   // Register writes
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         trigger_out_enable      <= 1'b0;
         trigger_out_source_mode <= 2'h0;
         trig_div                <= TRIG_DIV_RST;
         ref_repeat_enable       <= REF_EN_RST;
         strap_override_enable   <= 1'b0;
         cmos_a_ref_mode         <= 2'h0;
         cmos_b_ref_mode         <= 2'h0;
         overrange_flag_enable   <= 1'b0;
      end else if (wr_in) begin
         if (addr_in == TRIG_CTRL_ADDR) begin
            trigger_out_enable      <= wdata_in[TRIG_EN_BIT];
            trigger_out_source_mode <= wdata_in[TRIG_MODE_LSB +: 2];
            trig_div                <= wdata_in[TRIG_DIV_LSB +: TRIG_DIV_W];
         end
         if (addr_in == CLK_CFG_ADDR) begin
            ref_repeat_enable     <= wdata_in[REF_EN_BIT];
            strap_override_enable <= wdata_in[OVR_BIT];
            cmos_a_ref_mode       <= wdata_in[MODE_A_LSB +: 2];
            cmos_b_ref_mode       <= wdata_in[MODE_B_LSB +: 2];
            overrange_flag_enable <= wdata_in[FLAG_EN_BIT];
         end
      end
   end

   // Register reads, data one cycle after the strobe
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_out <= '0;
      end else if (rd_in) begin
         unique case (addr_in)
            TRIG_CTRL_ADDR: rdata_out <= DATA_W'({trig_div, 5'h00,
               trigger_out_source_mode, trigger_out_enable});
            CLK_CFG_ADDR: rdata_out <= DATA_W'({overrange_flag_enable,
               cmos_b_ref_mode, cmos_a_ref_mode, strap_override_enable,
               ref_repeat_enable});
            STATUS_ADDR: rdata_out <= DATA_W'({out_q, pin_s});
            default: rdata_out <= '0;
         endcase
      end else begin
         rdata_out <= '0;
      end
   end

   // Reference source and its dividers
   assign ref_src = pin_s[P_SEL] ? pin_s[P_SREF] : pin_s[P_DREF];

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ref_prev <= 1'b0;
         ref_div2 <= 1'b0;
         ref_div4 <= 1'b0;
      end else begin
         ref_prev <= ref_src;
         if (ref_src && !ref_prev) begin
            ref_div2 <= !ref_div2;
            if (ref_div2) begin
               ref_div4 <= !ref_div4;
            end
         end
      end
   end

   // Serializer PLL divider, toggles every trig_div rising edges
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         spll_prev <= 1'b0;
         spll_div  <= 1'b0;
         spll_cnt  <= '0;
      end else begin
         spll_prev <= pin_s[P_SPLL];
         if (pin_s[P_SPLL] && !spll_prev) begin
            if (spll_cnt + 8'h01 >= trig_div) begin
               spll_cnt <= '0;
               spll_div <= !spll_div;
            end else begin
               spll_cnt <= spll_cnt + 8'h01;
            end
         end
      end
   end

   // Requested source per output
   assign mode_a = strap_override_enable ? cmos_a_ref_mode
                                         : pin_s[P_ST1 -: 2];

   always_comb begin
      want[O_REF] = SRC_OFF;
      want[O_TRG] = SRC_OFF;
      want[O_A]   = SRC_OFF;
      want[O_B]   = SRC_OFF;
      if (!pin_s[P_PD]) begin
         if (pin_s[P_PLL] && ref_repeat_enable) begin
            want[O_REF] = SRC_REF;
         end
         if (trigger_out_enable) begin
            if (trigger_out_source_mode == TRIG_MODE_TS) begin
               want[O_TRG] = SRC_TS;
            end else if (trigger_out_source_mode == TRIG_MODE_SPLL) begin
               want[O_TRG] = SRC_SPLL;
            end
         end
         if (mode_a != 2'h0) begin
            want[O_A] = SRC_REF + SRC_W'(mode_a) - 3'h1;
         end else if (overrange_flag_enable && quad_part_in) begin
            want[O_A] = SRC_FLAG;
         end
         if (!strap_override_enable) begin
            if (pin_s[P_ST1 -: 2] != 2'h0) begin
               want[O_B] = SRC_REF;
            end else if (overrange_flag_enable && quad_part_in) begin
               want[O_B] = SRC_FLAG;
            end
         end else if (cmos_b_ref_mode != 2'h0) begin
            if (cmos_a_ref_mode != 2'h0) begin
               want[O_B] = SRC_REF + SRC_W'(cmos_b_ref_mode) - 3'h1;
            end
         end else if (overrange_flag_enable && quad_part_in) begin
            want[O_B] = SRC_FLAG;
         end
      end
   end

   // Glitch-free switch and output flop, one per output
   for (genvar i = 0; i < NOUT; i++) begin : g_out
      logic flag;
      assign flag = (i == O_B) ? overrange_d_in : overrange_c_in;
      assign src[i] = {1'b0, pin_s[P_TS], spll_div, flag, ref_div4,
                       ref_div2, ref_src, 1'b0};

      always_ff @(posedge clk_in) begin
         if (rst_in) begin
            cur[i] <= SRC_OFF;
         end else if (want[i] != cur[i] && !out_q[i]
                      && !src[i][cur[i]] && !src[i][want[i]]) begin
            cur[i] <= want[i];
         end
      end

      always_ff @(posedge clk_in) begin
         if (rst_in) begin
            out_q[i] <= 1'b0;
         end else begin
            out_q[i] <= src[i][cur[i]];
         end
      end

      chk_glitch_free_switch: assert property (
         @(posedge clk_in) disable iff (rst_in)
         cur[i] != $past(cur[i])
         |-> !out_q[i] && !$past(out_q[i]))
         else $error("source switched while output high");
      chk_static_when_off: assert property (
         @(posedge clk_in) disable iff (rst_in)
         cur[i] == SRC_OFF |=> !out_q[i])
         else $error("disabled output toggles");
   end

   assign ref_repeat_out    = out_q[O_REF];
   assign trigger_clock_out = out_q[O_TRG];
   assign cmos_clk_out_a    = out_q[O_A];
   assign cmos_clk_out_b    = out_q[O_B];

   chk_ref_source_follow: assert property (
      @(posedge clk_in) disable iff (rst_in)
      cur[O_REF] == SRC_REF |=> ref_repeat_out == $past(ref_src))
      else $error("reference repeat does not follow selected reference");
   chk_ref_enable_clear: assert property (
      @(posedge clk_in) disable iff (rst_in)
      wr_in && addr_in == CLK_CFG_ADDR && !wdata_in[REF_EN_BIT]
      |=> want[O_REF] == SRC_OFF)
      else $error("reference repeat not released by enable bit");
   chk_power_down_gate: assert property (
      @(posedge clk_in) disable iff (rst_in)
      pin_s[P_PD] |-> want[O_REF] == SRC_OFF && want[O_TRG] == SRC_OFF
                   && want[O_A] == SRC_OFF && want[O_B] == SRC_OFF)
      else $error("output requested during power-down");
   chk_trig_reset_off: assert property (
      @(posedge clk_in) $fell(rst_in) |-> !trigger_out_enable
                                          && !trigger_clock_out)
      else $error("trigger output on after reset");
   chk_trig_ts_repeat: assert property (
      @(posedge clk_in) disable iff (rst_in)
      cur[O_TRG] == SRC_TS |=> trigger_clock_out == $past(pin_s[P_TS]))
      else $error("trigger output does not repeat timestamp");
   chk_override_a_mode: assert property (
      @(posedge clk_in) disable iff (rst_in)
      strap_override_enable && !pin_s[P_PD] && cmos_a_ref_mode == 2'h3
      |-> want[O_A] == SRC_DIV4)
      else $error("first output ignores register mode");
   chk_strap_b_undivided: assert property (
      @(posedge clk_in) disable iff (rst_in)
      !strap_override_enable && !pin_s[P_PD] && pin_s[P_ST1 -: 2] != 2'h0
      |-> want[O_B] == SRC_REF)
      else $error("second output divided under strap control");
   chk_b_needs_a: assert property (
      @(posedge clk_in) disable iff (rst_in)
      strap_override_enable && cmos_a_ref_mode == 2'h0
      |-> want[O_B] == SRC_OFF || want[O_B] == SRC_FLAG)
      else $error("second output clocks with first mode zero");
   chk_flag_priority: assert property (
      @(posedge clk_in) disable iff (rst_in)
      want[O_A] == SRC_FLAG |-> mode_a == 2'h0)
      else $error("flag chosen over clock function");

   cov_trig_spll: cover property (
      @(posedge clk_in) disable iff (rst_in) cur[O_TRG] == SRC_SPLL);
   cov_a_div4: cover property (
      @(posedge clk_in) disable iff (rst_in) cur[O_A] == SRC_DIV4);
   cov_b_flag: cover property (
      @(posedge clk_in) disable iff (rst_in) cur[O_B] == SRC_FLAG);
endmodule

// ===== dv/cos_clk_partner.sv
// Far-side model: reference, serializer and timestamp sources
`timescale 1ns/1ps
module cos_clk_partner #(
   parameter int DREF_HALF = 4,
   parameter int SREF_HALF = 6,
   parameter int SPLL_HALF = 2
) (
   input  wire logic clk_in,
   output logic      dref_out,
   output logic      sref_out,
   output logic      spll_out,
   output logic      ts_out
);
   int n_d = 0;
   int n_s = 0;
   int n_p = 0;
   int n_t = 0;
   initial begin
      dref_out = 1'b0;
      sref_out = 1'b0;
      spll_out = 1'b0;
      ts_out   = 1'b0;
   end
   // Free-running sources, stepped just after each rising edge
   always @(posedge clk_in) begin
      n_d = (n_d + 1) % DREF_HALF;
      n_s = (n_s + 1) % SREF_HALF;
      n_p = (n_p + 1) % SPLL_HALF;
      if (n_d == 0) dref_out <= ~dref_out;
      if (n_s == 0) sref_out <= ~sref_out;
      if (n_p == 0) spll_out <= ~spll_out;
      // Trigger events with random spacing, at least three cycles apart
      if (n_t == 0) begin
         ts_out <= ~ts_out;
         n_t = 2 + $urandom_range(5);
      end else begin
         n_t--;
      end
   end
endmodule

// ===== dv/cos_clock_output_select_tb_top.sv
// Self-checking testbench for the clock output select block
`timescale 1ns/1ps
module cos_clock_output_select_tb_top;
   import cos_pkg::*;
   logic              clk_in, rst_in, wr_in, rd_in;
   logic [ADDR_W-1:0] addr_in;
   logic [DATA_W-1:0] wdata_in, rdata_out, v;
   logic              dref, sref, spll, ts, sel, pll_en, pd, quad, ovc, ovd;
   logic              o_ref, o_trg, o_a, o_b, watch;
   logic [1:0]        strap;
   logic [3:0]        outs, srcs, pouts, psrcs;
   logic [7:0]        dv;
   logic [2:0]        tc;
   int                cnt[8] = '{default: 0};
   int                d[8];
   int                run[4] = '{default: 0};
   int                err_count = 0;
   int                samples_checked = 0;
   int                min_hi = 1000;
   int                e;
   assign outs = {o_b, o_a, o_trg, o_ref};
   assign srcs = {ts, spll, sref, dref};
   cos_clk_partner part_u (.clk_in(clk_in), .dref_out(dref), .sref_out(sref),
      .spll_out(spll), .ts_out(ts));
   cos_clock_output_select dut_u (.clk_in(clk_in), .rst_in(rst_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .diff_ref_in(dref), .single_ended_ref_in(sref),
      .ref_source_single_ended_sel(sel), .pll_enable_in(pll_en),
      .power_down_pin(pd), .clock_strap_pins(strap), .timestamp_in(ts),
      .serdes_pll_in(spll), .quad_part_in(quad), .overrange_c_in(ovc),
      .overrange_d_in(ovd), .ref_repeat_out(o_ref), .trigger_clock_out(o_trg),
      .cmos_clk_out_a(o_a), .cmos_clk_out_b(o_b));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // Rising-edge counters of all outputs and sources, high-pulse widths of the CMOS outputs
   always @(posedge clk_in) begin
      for (int i = 0; i < 4; i++) begin
         if (outs[i] === 1'b1 && pouts[i] === 1'b0) cnt[i]++;
         if (srcs[i] === 1'b1 && psrcs[i] === 1'b0) cnt[i + 4]++;
         if (i >= 2 && watch && outs[i] === 1'b1) run[i]++;
         else begin
            if (i >= 2 && watch && run[i] > 0 && run[i] < min_hi) min_hi = run[i];
            run[i] = 0;
         end
      end
      pouts = outs;
      psrcs = srcs;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string msg);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   function automatic logic near(input int got, input int exp);
      return (got >= exp - 1) && (got <= exp + 1);
   endfunction
   function automatic int exp_a(input logic [1:0] m, input int r);
      return (m == 2'h0) ? 0 : r / (1 << (m - 2'h1));
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] val);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= val;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] val);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in   <= 1'b0;
      #1 val = rdata_out;
   endtask
   task automatic settle;
      repeat (40) @(posedge clk_in);
   endtask
   task automatic win(input int n);
      int b[8];
      b = cnt;
      repeat (n) @(posedge clk_in);
      foreach (d[i]) d[i] = cnt[i] - b[i];
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk_in);
      err_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      close_out();
   end
   initial begin
      {wr_in, rd_in, sel, pd, quad, ovc, ovd, watch} = 8'h00;
      {rst_in, pll_en} = 2'b11;
      addr_in = 8'h00;
      wdata_in = 32'h0000_0000;
      strap = 2'b01;
      void'($urandom(32'hdd82fa28));
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(TRIG_CTRL_ADDR, v); check(v, 32'h0000_0100, "trig reset");
      rd(CLK_CFG_ADDR, v); check(v, 32'h0000_0001, "cfg reset");
      wr(8'h0C, 32'hFFFF_FFFF);
      rd(8'h0C, v); check(v, 32'h0000_0000, "unmapped read");
      rd(TRIG_CTRL_ADDR, v); check(v, 32'h0000_0100, "unmapped write");
      settle(); win(256);
      check(d[O_TRG], 0, "trig at startup");
      check(near(d[O_REF], d[4]), 1'b1, "ref repeat on");
      check(near(d[O_A], d[4]), 1'b1, "cmos a at startup");
      $display("test reset done");
      sel <= 1'b1; settle(); win(256);
      check(near(d[O_REF], d[5]), 1'b1, "single-ended ref");
      pll_en <= 1'b0; settle(); win(128);
      check(d[O_REF], 0, "pll off");
      check(o_ref, 1'b0, "pll off level");
      pll_en <= 1'b1; sel <= 1'b0;
      wr(CLK_CFG_ADDR, 32'h0000_0000); settle(); win(128);
      check(d[O_REF], 0, "ref disabled");
      wr(CLK_CFG_ADDR, 32'h0000_0001);
      $display("test ref repeat done");
      for (int s = 0; s < 4; s++) begin
         strap <= s[1:0]; settle(); win(256);
         check(near(d[O_A], exp_a(s[1:0], d[4])), 1'b1, "strap a");
         check(near(d[O_B], s == 0 ? 0 : d[4]), 1'b1, "strap b");
      end
      wr(CLK_CFG_ADDR, 32'h0000_0041);
      {quad, ovc, ovd} <= 3'b111; settle(); win(256);
      check(near(d[O_A], exp_a(2'h3, d[4])), 1'b1, "clock over flag");
      {ovc, ovd} <= 2'b00; strap <= 2'b00; settle();
      {ovc, ovd} <= 2'b11; settle();
      check(o_a, 1'b1, "flag a");
      check(o_b, 1'b1, "flag b");
      {ovc, ovd, quad} <= 3'b000; settle();
      {ovc, ovd} <= 2'b11; settle();
      check(o_a, 1'b0, "no flag on dual part");
      {ovc, ovd, quad} <= 3'b001;
      $display("test straps done");
      watch <= 1'b1;
      for (int k = 0; k < 16; k++) begin
         strap <= 2'($urandom_range(3));
         wr(CLK_CFG_ADDR, {26'h0, k[3:2], k[1:0], 2'b11});
         settle(); win(256);
         check(near(d[O_A], exp_a(k[1:0], d[4])), 1'b1, "reg a");
         e = (k[1:0] == 2'h0) ? 0 : exp_a(k[3:2], d[4]);
         check(near(d[O_B], e), 1'b1, "reg b");
      end
      watch <= 1'b0;
      check(min_hi >= 4, 1'b1, "runt pulse");
      wr(CLK_CFG_ADDR, 32'h0000_000B); settle(); win(256);
      check(near(d[O_A], d[4] / 2), 1'b1, "single clock a");
      check(d[O_B], 0, "single clock b");
      $display("test override done");
      for (int i = 0; i < 16; i++) begin
         dv = 8'($urandom_range(4));
         tc = i[2:0];
         wr(TRIG_CTRL_ADDR, {16'h0, dv, 5'h0, tc});
         settle(); win(256);
         if (!tc[0] || !tc[1]) e = 0;
         else if (!tc[2]) e = d[6] / (2 * (dv == 8'h00 ? 1 : int'(dv)));
         else e = d[7];
         check(near(d[O_TRG], e), 1'b1, "trigger");
      end
      $display("test trigger done");
      wr(TRIG_CTRL_ADDR, 32'h0000_0103);
      strap <= 2'b01; settle();
      pd <= 1'b1; settle(); win(128);
      for (int i = 0; i < 4; i++) begin
         check(d[i], 0, "power-down edges");
      end
      check(outs, 4'h0, "power-down level");
      rd(STATUS_ADDR, v);
      check(v & 32'hFFFF_FE7C, 32'h0000_0038, "status pins");
      $display("test power-down done");
      close_out();
   end
endmodule
